// [evt_pkg.sv]
package evt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SP     = 8'h04;
  localparam logic [7:0] OFS_PID1_A = 8'h08;
  localparam logic [7:0] OFS_PID1_D = 8'h0c;
  localparam logic [7:0] OFS_SWAP_PARAM_SET_A = 8'h10;
  localparam logic [7:0] OFS_SWAP_PARAM_SET_D = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_PEAK   = 8'h1c;
  localparam logic [7:0] OFS_DEV    = 8'h20;
  localparam logic [7:0] OFS_RATE   = 8'h24;
  localparam logic [7:0] OFS_HEATER = 8'h28;
  localparam logic [7:0] OFS_DEMAND = 8'h2c;

  // Control register fields
  localparam int CTRL_FN_LSB   = 0;
  localparam int CTRL_FMT_BIT  = 4;
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL_FILE_BIT = 7;
  localparam int CTRL_CT_BIT   = 8;
  localparam int CTRL_W        = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

  // Timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned PEAK_HOLD_S   = 6;
  localparam int unsigned RELOAD_HOLD_S = 3;
  localparam int unsigned RATE_WIN_S    = 60;

  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_SP2 = 4'h1, FN_SWAP_PARAM_SET = 4'h2, FN_SP_PID = 4'h3,
    FN_CLR1 = 4'h4, FN_CLR2 = 4'h5, FN_CLR_BOTH = 4'h6,
    FN_KILL1 = 4'h7, FN_KILL2 = 4'h8, FN_KILL_BOTH = 4'h9, FN_LOCK = 4'ha
  } evt_fn_e;

  typedef enum logic [1:0] {
    SPM_PRIMARY = 2'h0, SPM_DUAL = 2'h1, SPM_RAMP_MIN = 2'h2, SPM_RAMP_HOUR = 2'h3
  } sp_mode_e;

  typedef struct packed {
    logic [15:0] prop_band;
    logic [15:0] integral_time;
    logic [15:0] derivative_time;
  } pid_set_s;

  typedef struct packed {
    logic [15:0] primary_setpoint;
    logic [15:0] secondary_setpoint;
    pid_set_s    pid;
  } param_file_s;

  // Default files: 0 for Celsius, 1 for Fahrenheit
  localparam param_file_s DFLT_FILE0 = '{16'h0064, 16'h0032, '{16'h000a, 16'h0064, 16'h0019}};
  localparam param_file_s DFLT_FILE1 = '{16'h00d4, 16'h007a, '{16'h00b4, 16'h0064, 16'h00fa}};

endpackage

// [event_input_function_logic.sv]
`timescale 1ns/10ps
`default_nettype none
module event_input_function_logic
  import evt_pkg::*;
#(
  parameter int unsigned PEAK_HOLD_CYC   = PEAK_HOLD_S * CLK_HZ,
  parameter int unsigned RELOAD_HOLD_CYC = RELOAD_HOLD_S * CLK_HZ,
  parameter int unsigned RATE_WIN_CYC    = RATE_WIN_S * CLK_HZ
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Pins
  input  wire logic        i_event_in,
  input  wire logic        i_key_peak_clear,
  input  wire logic        i_key_reload,
  // Control loop side
  input  wire logic [15:0] i_pv,
  input  wire logic [15:0] i_demand_one,
  input  wire logic [15:0] i_demand_two,
  input  wire logic [1:0]  i_alarm_cond,
  input  wire logic        i_tune_done,
  input  wire pid_set_s    i_tune_result,
  input  wire logic        i_heater_on,
  input  wire logic [15:0] i_in2_value,
  // Results
  output logic      [15:0] o_active_setpoint,
  output pid_set_s         o_active_pid,
  output logic      [15:0] o_deviation,
  output logic      [15:0] o_output_one_demand,
  output logic      [15:0] o_output_two_demand,
  output logic      [1:0]  o_alarm,
  output logic             o_param_locked,
  output logic             o_reload_pulse
);

  function automatic logic [29:0] hold_count(input logic held, input logic [29:0] cnt,
                                             input int unsigned lim);
    hold_count = !held ? 30'h0 : (cnt == lim[29:0]) ? cnt : cnt + 30'h1;
  endfunction

  // Synchronisers
  logic [2:0] pin_meta_r, pin_sync_r;
  logic       ev_prev_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
      ev_prev_r  <= 1'b0;
    end else begin
      pin_meta_r <= {i_key_reload, i_key_peak_clear, i_event_in};
      pin_sync_r <= pin_meta_r;
      ev_prev_r  <= pin_sync_r[0];
    end
  end

  logic ev, ev_rise, ev_fall;
  assign ev      = pin_sync_r[0];
  assign ev_rise = ev & ~ev_prev_r;
  assign ev_fall = ~ev & ev_prev_r;

  // Configuration state
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [15:0]       sp1_r, sp1_nxt, sp2_r, sp2_nxt;
  pid_set_s          pid1_r, pid1_nxt, swap_param_set_r, swap_param_set_nxt;

  evt_fn_e  fn;
  sp_mode_e sp_mode;
  assign fn      = evt_fn_e'(ctrl_r[CTRL_FN_LSB +: 4]);
  assign sp_mode = sp_mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);

  logic sp2_avail, use_sp2, use_swap_param_set, locked, kill1, kill2, clr1, clr2;
  logic [15:0] sp2_value, active_sp;
  pid_set_s    active_pid;
  assign sp2_avail = (sp_mode != SPM_PRIMARY);
  assign use_sp2   = ev & sp2_avail & (fn == FN_SP2 || fn == FN_SP_PID);
  assign use_swap_param_set  = ev & (fn == FN_SWAP_PARAM_SET || fn == FN_SP_PID);
  assign sp2_value = ctrl_r[CTRL_FMT_BIT] ? 16'(sp1_r + sp2_r) : sp2_r;
  assign active_sp  = use_sp2 ? sp2_value : sp1_r;
  assign active_pid = use_swap_param_set ? swap_param_set_r : pid1_r;
  assign locked    = ev & (fn == FN_LOCK);
  assign kill1     = ev & (fn == FN_KILL1 || fn == FN_KILL_BOTH);
  assign kill2     = ev & (fn == FN_KILL2 || fn == FN_KILL_BOTH);
  assign clr1      = ev & (fn == FN_CLR1 || fn == FN_CLR_BOTH);
  assign clr2      = ev & (fn == FN_CLR2 || fn == FN_CLR_BOTH);

  // APB decode; zero wait states
  logic access, wr_ok, mapped, is_param;
  assign access   = i_psel & i_penable;
  assign is_param = (i_paddr == OFS_CTRL) || (i_paddr == OFS_SP) ||
                    (i_paddr == OFS_PID1_A) || (i_paddr == OFS_PID1_D) ||
                    (i_paddr == OFS_SWAP_PARAM_SET_A) || (i_paddr == OFS_SWAP_PARAM_SET_D);
  assign mapped   = is_param || (i_paddr == OFS_STATUS) || (i_paddr == OFS_PEAK) ||
                    (i_paddr == OFS_DEV) || (i_paddr == OFS_RATE) ||
                    (i_paddr == OFS_HEATER) || (i_paddr == OFS_DEMAND);
  assign wr_ok    = access & i_pwrite & is_param & ~locked;
  assign o_pready = 1'b1;
  // Writes to read-only views are refused too, so software sees them fail
  assign o_pslverr = access & (~mapped | (i_pwrite & (~is_param | locked)));

  // Key hold timers
  logic [29:0] peak_cnt_r, peak_cnt_nxt, rel_cnt_r, rel_cnt_nxt;
  logic        peak_fire, reload_fire;
  assign peak_cnt_nxt = hold_count(pin_sync_r[1], peak_cnt_r, PEAK_HOLD_CYC);
  assign rel_cnt_nxt  = hold_count(pin_sync_r[2], rel_cnt_r, RELOAD_HOLD_CYC);
  assign peak_fire    = (peak_cnt_nxt == PEAK_HOLD_CYC[29:0]) &&
                        (peak_cnt_r != PEAK_HOLD_CYC[29:0]);
  assign reload_fire  = (rel_cnt_nxt == RELOAD_HOLD_CYC[29:0]) &&
                        (rel_cnt_r != RELOAD_HOLD_CYC[29:0]) && !locked;

  always_comb begin
    param_file_s dflt;
    dflt     = ctrl_r[CTRL_FILE_BIT] ? DFLT_FILE1 : DFLT_FILE0;
    ctrl_nxt = ctrl_r;
    sp1_nxt  = sp1_r;
    sp2_nxt  = sp2_r;
    pid1_nxt = pid1_r;
    swap_param_set_nxt = swap_param_set_r;
    if (wr_ok) begin
      unique case (i_paddr)
        OFS_CTRL:   ctrl_nxt = i_pwdata[CTRL_W-1:0];
        OFS_SP:     {sp2_nxt, sp1_nxt} = i_pwdata;
        OFS_PID1_A: {pid1_nxt.integral_time, pid1_nxt.prop_band} = i_pwdata;
        OFS_PID1_D: pid1_nxt.derivative_time = i_pwdata[15:0];
        OFS_SWAP_PARAM_SET_A: {swap_param_set_nxt.integral_time, swap_param_set_nxt.prop_band} = i_pwdata;
        OFS_SWAP_PARAM_SET_D: swap_param_set_nxt.derivative_time = i_pwdata[15:0];
        default: ;
      endcase
    end
    if (i_tune_done) begin
      if (use_swap_param_set) swap_param_set_nxt = i_tune_result;
      else          pid1_nxt = i_tune_result;
    end
    if (reload_fire) begin
      sp1_nxt  = dflt.primary_setpoint;
      sp2_nxt  = dflt.secondary_setpoint;
      pid1_nxt = dflt.pid;
      swap_param_set_nxt = dflt.pid;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r     <= CTRL_RST;
      sp1_r      <= DFLT_FILE0.primary_setpoint;
      sp2_r      <= DFLT_FILE0.secondary_setpoint;
      pid1_r     <= DFLT_FILE0.pid;
      swap_param_set_r     <= DFLT_FILE0.pid;
      peak_cnt_r <= 30'h0;
      rel_cnt_r  <= 30'h0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      sp1_r      <= sp1_nxt;
      sp2_r      <= sp2_nxt;
      pid1_r     <= pid1_nxt;
      swap_param_set_r     <= swap_param_set_nxt;
      peak_cnt_r <= peak_cnt_nxt;
      rel_cnt_r  <= rel_cnt_nxt;
    end
  end

  // Monitoring; read-only, nothing here feeds control
  logic [15:0] peak_hi_r, peak_hi_nxt, peak_lo_r, peak_lo_nxt;
  logic        peak_empty_r, peak_empty_nxt;
  logic [29:0] rate_cnt_r, rate_cnt_nxt;
  logic [15:0] pv_mark_r, pv_mark_nxt, rise_r, rise_nxt, fall_r, fall_nxt;
  logic        mark_ok_r, mark_ok_nxt;
  logic [15:0] heater_r, heater_nxt;

  always_comb begin
    logic [15:0] rate;
    rate           = 16'(i_pv - pv_mark_r);
    peak_empty_nxt = 1'b0;
    peak_hi_nxt    = peak_hi_r;
    peak_lo_nxt    = peak_lo_r;
    if (peak_empty_r || peak_fire) begin
      peak_hi_nxt = i_pv;
      peak_lo_nxt = i_pv;
    end else begin
      if ($signed(i_pv) > $signed(peak_hi_r)) peak_hi_nxt = i_pv;
      if ($signed(i_pv) < $signed(peak_lo_r)) peak_lo_nxt = i_pv;
    end
    rate_cnt_nxt = rate_cnt_r + 30'h1;
    pv_mark_nxt  = pv_mark_r;
    mark_ok_nxt  = mark_ok_r;
    rise_nxt     = rise_r;
    fall_nxt     = fall_r;
    if (rate_cnt_r == 30'(RATE_WIN_CYC - 1)) begin
      rate_cnt_nxt = 30'h0;
      pv_mark_nxt  = i_pv;
      mark_ok_nxt  = 1'b1;
      if (mark_ok_r && $signed(rate) > $signed(rise_r)) rise_nxt = rate;
      if (mark_ok_r && $signed(rate) < $signed(fall_r)) fall_nxt = rate;
    end
    heater_nxt = heater_r;
    if (!ctrl_r[CTRL_CT_BIT] || i_heater_on) heater_nxt = i_in2_value;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      peak_empty_r <= 1'b1;
      peak_hi_r    <= 16'h0;
      peak_lo_r    <= 16'h0;
      rate_cnt_r   <= 30'h0;
      pv_mark_r    <= 16'h0;
      mark_ok_r    <= 1'b0;
      rise_r       <= 16'h0;
      fall_r       <= 16'h0;
      heater_r     <= 16'h0;
    end else begin
      peak_empty_r <= peak_empty_nxt;
      peak_hi_r    <= peak_hi_nxt;
      peak_lo_r    <= peak_lo_nxt;
      rate_cnt_r   <= rate_cnt_nxt;
      pv_mark_r    <= pv_mark_nxt;
      mark_ok_r    <= mark_ok_nxt;
      rise_r       <= rise_nxt;
      fall_r       <= fall_nxt;
      heater_r     <= heater_nxt;
    end
  end

  // Control outputs
  logic [15:0] sp_out_nxt, dev_nxt, dem1_nxt, dem2_nxt;
  logic [1:0]  alarm_nxt;

  always_comb begin
    sp_out_nxt = active_sp;
    dev_nxt    = 16'(i_pv - active_sp);
    dem1_nxt   = kill1 ? 16'h0 : i_demand_one;
    dem2_nxt   = kill2 ? 16'h0 : i_demand_two;
    // Clear holds while active, so a latched alarm re-arms on release
    alarm_nxt  = (o_alarm | i_alarm_cond) & ~{clr2, clr1};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_active_setpoint   <= DFLT_FILE0.primary_setpoint;
      o_active_pid        <= DFLT_FILE0.pid;
      o_deviation         <= 16'h0;
      o_output_one_demand <= 16'h0;
      o_output_two_demand <= 16'h0;
      o_alarm             <= 2'h0;
      o_param_locked      <= 1'b0;
      o_reload_pulse      <= 1'b0;
    end else begin
      o_active_setpoint   <= sp_out_nxt;
      o_active_pid        <= active_pid;
      o_deviation         <= dev_nxt;
      o_output_one_demand <= dem1_nxt;
      o_output_two_demand <= dem2_nxt;
      o_alarm             <= alarm_nxt;
      o_param_locked      <= locked;
      o_reload_pulse      <= reload_fire;
    end
  end

  // Read mux; reading views has no side effect on control
  always_comb begin
    o_prdata = 32'h0;
    if (access && !i_pwrite) begin
      unique case (i_paddr)
        OFS_CTRL:   o_prdata = {23'h0, ctrl_r};
        OFS_SP:     o_prdata = {sp2_r, sp1_r};
        OFS_PID1_A: o_prdata = {pid1_r.integral_time, pid1_r.prop_band};
        OFS_PID1_D: o_prdata = {16'h0, pid1_r.derivative_time};
        OFS_SWAP_PARAM_SET_A: o_prdata = {swap_param_set_r.integral_time, swap_param_set_r.prop_band};
        OFS_SWAP_PARAM_SET_D: o_prdata = {16'h0, swap_param_set_r.derivative_time};
        OFS_STATUS: o_prdata = {24'h0, o_alarm, use_swap_param_set, use_sp2, locked, sp2_avail, 1'b0, ev};
        OFS_PEAK:   o_prdata = {peak_lo_r, peak_hi_r};
        OFS_DEV:    o_prdata = {o_active_setpoint, o_deviation};
        OFS_RATE:   o_prdata = {fall_r, rise_r};
        OFS_HEATER: o_prdata = {16'h0, heater_r};
        OFS_DEMAND: o_prdata = {o_output_two_demand, o_output_one_demand};
        default:    o_prdata = 32'h0;
      endcase
    end
  end

  // Checks
  sequence s_fn_active(evt_fn_e f);
    ev && fn == f;
  endsequence

  sequence s_release(evt_fn_e f);
    ev_fall && fn == f;
  endsequence

  a_sync_two_stage: assert property (@(posedge i_clk) disable iff (i_rst)
    ##2 (pin_sync_r[0] == $past(i_event_in, 2)))
    else $error("event input not synchronised in two stages");

  a_none_primary: assert property (@(posedge i_clk) disable iff (i_rst)
    fn == FN_NONE |=> o_active_setpoint == $past(sp1_r) && o_active_pid == $past(pid1_r))
    else $error("code 0 did not use primary set");

  a_sp2_swap: assert property (@(posedge i_clk) disable iff (i_rst)
    s_fn_active(FN_SP2) ##0 (sp2_avail && !ctrl_r[CTRL_FMT_BIT])
    |=> o_active_setpoint == $past(sp2_r))
    else $error("secondary set point not used");

  a_offset_sp2: assert property (@(posedge i_clk) disable iff (i_rst)
    s_fn_active(FN_SP_PID) ##0 (sp2_avail && ctrl_r[CTRL_FMT_BIT])
    |=> o_active_setpoint == $past(16'(sp1_r + sp2_r)) && o_active_pid == $past(swap_param_set_r))
    else $error("offset set point or PID swap wrong");

  a_sp2_gated: assert property (@(posedge i_clk) disable iff (i_rst)
    sp_mode == SPM_PRIMARY |=> o_active_setpoint == $past(sp1_r))
    else $error("second set point used in primary mode");

  a_swap_param_set_swap: assert property (@(posedge i_clk) disable iff (i_rst)
    s_fn_active(FN_SWAP_PARAM_SET) |=> o_active_pid == $past(swap_param_set_r))
    else $error("second PID set not used");

  a_tune_target: assert property (@(posedge i_clk) disable iff (i_rst)
    i_tune_done && use_swap_param_set && !reload_fire |=> swap_param_set_r == $past(i_tune_result))
    else $error("tuning result not stored in second set");

  a_alarm_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    s_fn_active(FN_CLR_BOTH) |=> o_alarm == 2'h0)
    else $error("alarms not cleared while event active");

  a_alarm_retrig: assert property (@(posedge i_clk) disable iff (i_rst)
    s_release(FN_CLR1) ##0 i_alarm_cond[0] |=> o_alarm[0])
    else $error("alarm 1 not retriggered on release");

  a_kill_both: assert property (@(posedge i_clk) disable iff (i_rst)
    ev_rise && fn == FN_KILL_BOTH |=> o_output_one_demand == 16'h0 && o_output_two_demand == 16'h0)
    else $error("outputs not zeroed on activation");

  a_kill_release: assert property (@(posedge i_clk) disable iff (i_rst)
    s_release(FN_KILL2) |=> o_output_two_demand == $past(i_demand_two))
    else $error("output 2 not restored on release");

  a_lock_reject: assert property (@(posedge i_clk) disable iff (i_rst)
    access && i_pwrite && locked && !i_tune_done |-> o_pslverr ##1 $stable(sp1_r) && $stable(ctrl_r))
    else $error("parameter changed while locked");

  a_heater_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    ctrl_r[CTRL_CT_BIT] && !i_heater_on |=> $stable(heater_r))
    else $error("heater current changed while heater off");

  a_dev_value: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> o_deviation == 16'($past(i_pv) - o_active_setpoint))
    else $error("deviation is not process minus set value");

endmodule // event_input_function_logic
`default_nettype wire

// [event_contact.sv]
`timescale 1ns/10ps
`default_nettype none
module event_contact (
  // Clock
  input  wire logic       i_clk,
  // Bench command
  input  wire logic       i_close,
  input  wire logic [3:0] i_delay,
  // Contact level, high while closed
  output logic            o_level
);
  logic [3:0] wait_r;
  initial o_level = 1'b0;
  initial wait_r = 4'h0;
  // Slow contacts settle only after the chosen delay, never in mid-cycle
  always @(posedge i_clk) begin
    if (i_close == o_level) begin
      wait_r <= 4'h0;
    end else if (wait_r >= i_delay) begin
      o_level <= i_close;
      wait_r  <= 4'h0;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // event_contact
`default_nettype wire

// [event_input_function_logic_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module event_input_function_logic_bench;
  import evt_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        ev_cmd, ev_lvl, key_pk, key_rl, tdone, htr, locked, rpulse;
  logic [3:0]  ev_dly;
  logic [15:0] pv, d1, d2, in2, asp, dev, o1, o2;
  logic [1:0]  acond, alarm;
  pid_set_s    tres, apid;
  int          fails = 0;
  int          num_checks = 0;
  localparam logic [47:0] P1 = 48'h0100_0200_0300;
  localparam logic [47:0] P2 = 48'h0400_0500_0600;

  always #50 clk = ~clk;

  event_contact i_event_contact (.i_clk(clk), .i_close(ev_cmd), .i_delay(ev_dly), .o_level(ev_lvl));

  event_input_function_logic #(.PEAK_HOLD_CYC(20), .RELOAD_HOLD_CYC(10), .RATE_WIN_CYC(16))
    i_event_input_function_logic (
    .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_event_in(ev_lvl), .i_key_peak_clear(key_pk),
    .i_key_reload(key_rl), .i_pv(pv), .i_demand_one(d1), .i_demand_two(d2),
    .i_alarm_cond(acond), .i_tune_done(tdone), .i_tune_result(tres), .i_heater_on(htr),
    .i_in2_value(in2), .o_active_setpoint(asp), .o_active_pid(apid), .o_deviation(dev),
    .o_output_one_demand(o1), .o_output_two_demand(o2), .o_alarm(alarm),
    .o_param_locked(locked), .o_reload_pulse(rpulse));

  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; data and error taken at the edge that sees pready high
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    logic [31:0] r;
    logic        e;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      r = prdata;
      e = pslverr;
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!w) begin
      chk($sformatf("read %h", a), r, ed);
    end
    chk($sformatf("pslverr %h", a), e, ee);
  endtask

  function automatic logic [31:0] ctl(int fn, int fmt, int md, int fl, int ct);
    return {23'h0, ct[0], fl[0], md[1:0], fmt[0], fn[3:0]};
  endfunction

  // Generous settle time covers slow contact plus synchroniser
  task automatic evt(input logic v);
    ev_cmd <= v;
    repeat (12) @(posedge clk);
    #1;
  endtask

  initial begin
    #(100 * 8000);
    fails++;
    end_sim();
  end

  initial begin
    int np;
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    ev_cmd = 0; ev_dly = 4'h5; key_pk = 0; key_rl = 0; tdone = 0; tres = '0;
    htr = 0; in2 = 16'h0011; pv = 16'h0150; d1 = 16'h1111; d2 = 16'h2222; acond = 0;
    np = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, OFS_CTRL, 0, 32'h0, 1'b0);
    acc(1'b0, OFS_DEV, 0, 32'h0064_00ec, 1'b0);
    acc(1'b0, 8'h30, 0, 32'h0, 1'b1);
    acc(1'b1, OFS_SP, 32'h0020_0100, 0, 1'b0);
    acc(1'b1, OFS_PID1_A, 32'h0200_0100, 0, 1'b0);
    acc(1'b1, OFS_PID1_D, 32'h0000_0300, 0, 1'b0);
    acc(1'b1, OFS_SWAP_PARAM_SET_A, 32'h0500_0400, 0, 1'b0);
    acc(1'b1, OFS_SWAP_PARAM_SET_D, 32'h0000_0600, 0, 1'b0);
    for (int f = 0; f < 4; f++) begin
      acc(1'b1, OFS_CTRL, ctl(f, 0, 1, 0, 0), 0, 1'b0);
      if (f == 0) begin
        evt(1'b1);
      end
      repeat (4) @(posedge clk);
      #1;
      chk("setpoint", asp, f[0] ? 16'h0020 : 16'h0100);
      chk("pid", apid, f[1] ? P2 : P1);
    end
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, OFS_CTRL, ctl(1, 0, m, 0, 0), 0, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      chk("sp mode", asp, (m == 0) ? 16'h0100 : 16'h0020);
    end
    acc(1'b1, OFS_CTRL, ctl(3, 1, 1, 0, 0), 0, 1'b0);
    repeat (4) @(posedge clk);
    #1;
    chk("sp offset", asp, 16'h0120);
    chk("pid offset", apid, P2);
    acc(1'b1, OFS_CTRL, ctl(2, 0, 1, 0, 0), 0, 1'b0);
    tres  <= 48'h0700_0800_0900;
    tdone <= 1'b1;
    @(posedge clk);
    tdone <= 1'b0;
    repeat (3) @(posedge clk);
    chk("tuned pid", apid, 48'h0700_0800_0900);
    acc(1'b0, OFS_SWAP_PARAM_SET_A, 0, 32'h0800_0700, 1'b0);
    acc(1'b0, OFS_PID1_A, 0, 32'h0200_0100, 1'b0);
    evt(1'b0);
    acond <= 2'b11;
    for (int f = 4; f < 7; f++) begin
      acc(1'b1, OFS_CTRL, ctl(f, 0, 0, 0, 0), 0, 1'b0);
      evt(1'b1);
      chk("alarm cleared", alarm, 2'b11 & ~(f - 3));
      if (f == 6) begin
        acond <= 2'b01;
      end
      evt(1'b0);
      chk("alarm retrig", alarm, (f == 6) ? 2'b01 : 2'b11);
      acond <= 2'b11;
    end
    ev_dly <= 4'h0;
    for (int f = 7; f < 10; f++) begin
      acc(1'b1, OFS_CTRL, ctl(f, 0, 0, 0, 0), 0, 1'b0);
      ev_cmd <= 1'b1;
      wait (ev_lvl === 1'b1);
      @(posedge clk);
      #1;
      chk("sync delay", o1, 16'h1111);
      evt(1'b1);
      chk("out1 off", o1, f[0] ? 16'h0000 : 16'h1111);
      chk("out2 off", o2, (f > 7) ? 16'h0000 : 16'h2222);
      evt(1'b0);
      chk("out restore", {o2, o1}, 32'h2222_1111);
    end
    acc(1'b1, OFS_CTRL, ctl(10, 0, 0, 0, 0), 0, 1'b0);
    evt(1'b1);
    chk("locked", locked, 1'b1);
    acc(1'b1, OFS_SP, 32'h0999_0999, 0, 1'b1);
    acc(1'b0, OFS_SP, 0, 32'h0020_0100, 1'b0);
    evt(1'b0);
    chk("unlocked", locked, 1'b0);
    pv <= 16'h0160;
    repeat (48) @(posedge clk);
    pv <= 16'h0140;
    repeat (48) @(posedge clk);
    acc(1'b0, OFS_RATE, 0, 32'hffe0_0010, 1'b0);
    acc(1'b0, OFS_PEAK, 0, 32'h0140_0160, 1'b0);
    acc(1'b0, OFS_DEV, 0, 32'h0100_0040, 1'b0);
    chk("deviation", dev, 16'h0040);
    chk("sp kept", asp, 16'h0100);
    key_pk <= 1'b1;
    repeat (25) @(posedge clk);
    key_pk <= 1'b0;
    acc(1'b0, OFS_PEAK, 0, 32'h0140_0140, 1'b0);
    acc(1'b1, OFS_CTRL, ctl(0, 0, 0, 0, 1), 0, 1'b0);
    htr <= 1'b1;
    in2 <= 16'h0033;
    repeat (4) @(posedge clk);
    htr <= 1'b0;
    in2 <= 16'h0044;
    repeat (4) @(posedge clk);
    acc(1'b0, OFS_HEATER, 0, 32'h0000_0033, 1'b0);
    acc(1'b1, OFS_CTRL, ctl(0, 0, 0, 1, 0), 0, 1'b0);
    key_rl <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      np += (rpulse === 1'b1);
    end
    @(posedge clk);
    key_rl <= 1'b0;
    chk("reload pulses", np, 1);
    acc(1'b0, OFS_SP, 0, 32'h007a_00d4, 1'b0);
    acc(1'b0, OFS_PID1_A, 0, 32'h0064_00b4, 1'b0);
    chk("reload sp", asp, 16'h00d4);
    end_sim();
  end
endmodule // event_input_function_logic_bench
`default_nettype wire
